/* File: pkg/wdog_pkg.sv */
// Purpose: constants shared by the watchdog and reset-cause block
// Assumes: 8-bit data registers, 16-bit data-space addresses
// Notes: i/o-instruction addresses are data-space offsets less a fixed bias
package wdog_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] CAUSE_DS_ADDR = 16'h0054;
	localparam logic [15:0] IO_SPACE_BIAS = 16'h0020;
	localparam logic [15:0] CAUSE_IO_ADDR = CAUSE_DS_ADDR - IO_SPACE_BIAS;
	localparam logic [15:0] CTRL_DS_ADDR = 16'h0060;

	// ----------------------------------------------------------------
	// reset_cause_flags fields
	// ----------------------------------------------------------------
	localparam int TEST_PORT_BIT = 4;
	localparam int DOG_BIT = 3;
	localparam int BROWNOUT_BIT = 2;
	localparam int PIN_BIT = 1;
	localparam int POWER_ON_BIT = 0;
	localparam int CAUSE_BITS = 5;
	localparam logic [4:0] CAUSE_RESET = 5'h00;

	// ----------------------------------------------------------------
	// watchdog_control fields
	// ----------------------------------------------------------------
	localparam int IRQ_FLAG_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int PRESCALE_HI_BIT = 5;
	localparam int UNLOCK_BIT = 4;
	localparam int RESET_EN_BIT = 3;
	localparam int PRESCALE_LO_MSB = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] PRESCALE_RESET = 4'h0;
	localparam logic [3:0] PRESCALE_MAX_CODE = 4'h9;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int UNLOCK_CYCLES = 4;
	localparam logic [1:0] UNLOCK_LAST = 2'(UNLOCK_CYCLES - 1);
	localparam int DOG_OSC_KHZ = 128;
	localparam int BASE_TIMEOUT_MS = 16;
	localparam int BASE_OSC_CYCLES = BASE_TIMEOUT_MS * DOG_OSC_KHZ;
	localparam int DOG_COUNT_W = 21;

endpackage

/* File: rtl/dog_counter.sv */
// Purpose: counts watchdog oscillator periods and flags a timeout
// Assumes: osc_level is synchronous to clock and far slower than it
// Notes: a shrinking limit below the count times out on the next tick
`timescale 1ns/1ps
module dog_counter
	import wdog_pkg::*;
#(
	parameter int CW = DOG_COUNT_W
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control
	input wire logic osc_level,
	input wire logic clear,
	input wire logic [CW-1:0] limit,
	// result
	output logic timeout
);

	typedef struct packed
	{
		logic osc_prev;
		logic [CW-1:0] count;
		logic timeout;
	} cnt_state_t;

	cnt_state_t st;
	cnt_state_t next_st;
	logic tick;

	assign tick = osc_level && !st.osc_prev;
	assign timeout = st.timeout;

	always_comb
	begin
		next_st = st;
		next_st.osc_prev = osc_level;
		next_st.timeout = 1'b0;
		if (clear)
		begin
			next_st.count = '0;
		end
		else if (tick)
		begin
			if (st.count >= limit - CW'(1))
			begin
				next_st.count = '0;
				next_st.timeout = 1'b1;
			end
			else
			begin
				next_st.count = st.count + CW'(1);
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule

/* File: rtl/wdog_reset_flags.sv */
// Purpose: watchdog control and reset-cause flags of a small controller
// Assumes: RST is the power-on reset; other resets arrive as one-cycle pulses
// Notes: registers reached by load/store (data space) or short i/o access
// Function
// - test-port reset sets its flag; power-on or writing zero clears it
// - watchdog system reset sets its flag; power-on or writing zero clears it
// - brown-out reset sets its flag; power-on or writing zero clears it
// - external pin reset sets its flag; power-on or writing zero clears it
// - power-on sets its flag; only a software zero write clears it
// - reset-cause register at data offset 0x54 and i/o address 0x34
// - watchdog control at data offset 0x60, data-space access only
// - timeout sets interrupt flag; vector or writing one clears it
// - interrupt taken only with global enable, local enable and pending flag
// - reset-enable and interrupt-enable bits select stopped, irq, reset, both
// - programmed always-on fuse forces system reset mode
// - combined mode: vector clears enable and flag, leaving reset mode
// - combined mode: second timeout before vector gives system reset
// - clearing reset-enable or changing prescale needs unlock; unlock lasts four cycles
// - reset-enable held at one while watchdog reset flag is set
// - prescale codes 0 to 9 give 2048 doubling to 1048576 oscillator cycles
// - watchdog counts a separate 128 kHz oscillator
// - restart instruction returns the counter to zero
// - timeout in reset mode gives a one-cycle system reset pulse
`timescale 1ns/1ps
module wdog_reset_flags
	import wdog_pkg::*;
#(
	parameter int DOG_BASE_CYCLES = BASE_OSC_CYCLES
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// register access
	input wire logic [15:0] ADDR,
	input wire logic IO_SPACE,
	input wire logic WRITE,
	input wire logic READ,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	// reset sources
	input wire logic PIN_RESET,
	input wire logic BROWNOUT_RESET,
	input wire logic TEST_PORT_RESET,
	// watchdog inputs
	input wire logic OSC_128K,
	input wire logic RESTART,
	input wire logic ALWAYS_ON_FUSE_N,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic VECTOR_ACK,
	// watchdog outputs
	output logic IRQ_REQ,
	output logic SYS_RESET
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [CAUSE_BITS-1:0] cause;
		logic irq_flag;
		logic irq_enable;
		logic unlock;
		logic [1:0] unlock_count;
		logic timeout_reset_enable;
		logic [3:0] prescale;
		logic sys_reset;
		logic [7:0] rdata;
	} wdog_state_t;

	wdog_state_t st;
	wdog_state_t next_st;

	logic fuse_prog;
	logic eff_wde;
	logic eff_ie;
	logic dog_on;
	logic dog_timeout;
	logic do_reset;
	logic set_irq;
	logic sys_evt;
	logic wr_cause;
	logic wr_ctrl;
	logic rd_cause;
	logic rd_ctrl;
	logic [7:0] ctrl_view;
	logic [DOG_COUNT_W-1:0] limit;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic hits_cause(input logic io, input logic [15:0] addr);
		return io ? (addr == CAUSE_IO_ADDR) : (addr == CAUSE_DS_ADDR);
	endfunction

	function automatic logic hits_ctrl(input logic io, input logic [15:0] addr);
		return !io && (addr == CTRL_DS_ADDR);
	endfunction

	function automatic logic [DOG_COUNT_W-1:0] timeout_cycles(input logic [3:0] code);
		logic [3:0] sel;
		sel = (code > PRESCALE_MAX_CODE) ? PRESCALE_MAX_CODE : code;
		return DOG_COUNT_W'(DOG_BASE_CYCLES) << sel;
	endfunction

	// ----------------------------------------------------------------
	// decode and mode
	// ----------------------------------------------------------------
	assign wr_cause = WRITE && hits_cause(IO_SPACE, ADDR);
	assign wr_ctrl = WRITE && hits_ctrl(IO_SPACE, ADDR);
	assign rd_cause = READ && hits_cause(IO_SPACE, ADDR);
	assign rd_ctrl = READ && hits_ctrl(IO_SPACE, ADDR);

	assign fuse_prog = !ALWAYS_ON_FUSE_N;
	// reset enable forced by the fuse or a pending watchdog reset flag
	assign eff_wde = st.timeout_reset_enable || st.cause[DOG_BIT] || fuse_prog;
	assign eff_ie = st.irq_enable && !fuse_prog;
	assign dog_on = eff_wde || eff_ie;
	// combined mode resets only when the earlier interrupt is still pending
	assign do_reset = dog_timeout && eff_wde && (!eff_ie || st.irq_flag);
	assign set_irq = dog_timeout && eff_ie && !do_reset;
	assign sys_evt = PIN_RESET || BROWNOUT_RESET || TEST_PORT_RESET || st.sys_reset;
	assign limit = timeout_cycles(st.prescale);

	assign ctrl_view = {st.irq_flag, eff_ie, st.prescale[3], st.unlock, eff_wde,
		st.prescale[PRESCALE_LO_MSB:0]};

	assign IRQ_REQ = GLOBAL_IRQ_EN && eff_ie && st.irq_flag;
	assign SYS_RESET = st.sys_reset;
	assign RDATA = st.rdata;

	// ----------------------------------------------------------------
	// oscillator counter
	// ----------------------------------------------------------------
	dog_counter #(
		.CW(DOG_COUNT_W)
	) dog_counter_i (
		.clock(CLOCK),
		.rst(RST),
		.osc_level(OSC_128K),
		.clear(RESTART || sys_evt || !dog_on),
		.limit(limit),
		.timeout(dog_timeout)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;

		// reset cause: a zero write clears, a one write keeps, events win
		if (wr_cause)
		begin
			next_st.cause = st.cause & WDATA[CAUSE_BITS-1:0];
		end
		next_st.cause[TEST_PORT_BIT] = next_st.cause[TEST_PORT_BIT] || TEST_PORT_RESET;
		next_st.cause[DOG_BIT] = next_st.cause[DOG_BIT] || do_reset;
		next_st.cause[BROWNOUT_BIT] = next_st.cause[BROWNOUT_BIT] || BROWNOUT_RESET;
		next_st.cause[PIN_BIT] = next_st.cause[PIN_BIT] || PIN_RESET;

		// unlock window countdown
		if (st.unlock)
		begin
			if (st.unlock_count == 2'h0)
			begin
				next_st.unlock = 1'b0;
			end
			else
			begin
				next_st.unlock_count = st.unlock_count - 2'h1;
			end
		end

		// control writes
		if (wr_ctrl)
		begin
			next_st.irq_enable = WDATA[IRQ_EN_BIT];
			if (WDATA[UNLOCK_BIT] && WDATA[RESET_EN_BIT] && !st.unlock)
			begin
				next_st.unlock = 1'b1;
				next_st.unlock_count = UNLOCK_LAST;
				next_st.timeout_reset_enable = 1'b1;
			end
			else if (st.unlock)
			begin
				next_st.timeout_reset_enable = WDATA[RESET_EN_BIT];
				next_st.prescale = {WDATA[PRESCALE_HI_BIT], WDATA[PRESCALE_LO_MSB:0]};
			end
			else
			begin
				next_st.timeout_reset_enable = st.timeout_reset_enable || WDATA[RESET_EN_BIT];
			end
		end

		// vector in combined mode drops the enable, leaving reset mode
		if (VECTOR_ACK && eff_wde)
		begin
			next_st.irq_enable = 1'b0;
		end

		// interrupt flag: timeout sets, vector or a one write clears
		next_st.irq_flag = set_irq ||
			(st.irq_flag && !VECTOR_ACK && !(wr_ctrl && WDATA[IRQ_FLAG_BIT]));

		// a chip reset returns the control register to its reset value
		if (sys_evt)
		begin
			next_st.irq_flag = CTRL_RESET[IRQ_FLAG_BIT];
			next_st.irq_enable = CTRL_RESET[IRQ_EN_BIT];
			next_st.unlock = CTRL_RESET[UNLOCK_BIT];
			next_st.unlock_count = 2'h0;
			next_st.timeout_reset_enable = CTRL_RESET[RESET_EN_BIT];
			next_st.prescale = PRESCALE_RESET;
		end

		next_st.sys_reset = do_reset;

		// read data
		if (rd_cause)
		begin
			next_st.rdata = {3'h0, st.cause};
		end
		else if (rd_ctrl)
		begin
			next_st.rdata = ctrl_view;
		end
		else if (READ)
		begin
			next_st.rdata = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			st <= '0;
			st.cause <= CAUSE_RESET | CAUSE_BITS'(1 << POWER_ON_BIT);
			st.rdata <= 8'h00;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	sequence seq_unlock_window;
		st.unlock [*4] ##1 !st.unlock;
	endsequence

	sequence seq_combined_ack;
		VECTOR_ACK && eff_wde && !dog_timeout && !sys_evt;
	endsequence

	a_reset_pulse_one: assert property (SYS_RESET |=> !SYS_RESET)
		else $error("system reset pulse longer than one cycle");

	a_dog_flag_set: assert property (do_reset |=> SYS_RESET && st.cause[DOG_BIT])
		else $error("watchdog reset without its flag");

	a_wde_held: assert property (st.cause[DOG_BIT] && dog_timeout && !eff_ie |=> SYS_RESET)
		else $error("reset enable reads zero while watchdog flag set");

	a_unlock_four: assert property ($rose(st.unlock) |-> seq_unlock_window)
		else $error("unlock window not four cycles");

	a_prescale_locked: assert property (!st.unlock && !sys_evt |=> $stable(st.prescale))
		else $error("prescale changed while locked");

	a_irq_gate: assert property (IRQ_REQ |-> GLOBAL_IRQ_EN && st.irq_enable && st.irq_flag)
		else $error("interrupt requested without enables");

	a_power_on_flag: assert property ($past(RST) |-> st.cause == 5'h01)
		else $error("cause flags wrong after power-on");

	a_vector_clears: assert property (seq_combined_ack |=> !st.irq_flag && !st.irq_enable)
		else $error("vector did not leave reset mode");

	a_second_timeout: assert property (dog_timeout && eff_wde && eff_ie && st.irq_flag
		|=> SYS_RESET)
		else $error("second timeout gave no reset");

	a_fuse_forces: assert property (fuse_prog && dog_timeout |=> SYS_RESET && !st.irq_flag)
		else $error("fuse did not force reset mode");

	a_cause_upper: assert property (rd_cause |=> RDATA[7:5] == 3'h0)
		else $error("unused cause bits read nonzero");

	a_pin_flag: assert property (PIN_RESET |=> st.cause[PIN_BIT])
		else $error("pin reset flag not set");

endmodule

/* File: bench/wdog_reset_flags_tb.sv */
// Purpose: self-checking bench for the watchdog and reset-cause block
// Assumes: small base count so the longest timeout stays short
// Notes: oscillator level toggles every two system clocks
`timescale 1ns/1ps
module wdog_reset_flags_tb
	import wdog_pkg::*;
();
	localparam int BASE = 4;
	localparam int OSC_PER = 4;
	localparam int LIMIT_CYCLES = 60000;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic io_space = 1'b0;
	logic write = 1'b0;
	logic read = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [2:0] src = 3'h0;
	logic osc = 1'b0;
	logic restart = 1'b1;
	logic fuse_n = 1'b1;
	logic gie = 1'b0;
	logic ack = 1'b0;
	logic irq_req;
	logic sys_reset;
	logic [7:0] exp;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int osc_div = 0;
	int sys_count = 0;
	int n;
	int base_count;
	int codes [5] = '{0, 1, 9, 10, 15};
	logic [7:0] src_bit [3] = '{8'h02, 8'h04, 8'h10};

	wdog_reset_flags #(.DOG_BASE_CYCLES(BASE)) wdog_reset_flags_i (
		.CLOCK(clock), .RST(rst), .ADDR(addr), .IO_SPACE(io_space), .WRITE(write),
		.READ(read), .WDATA(wdata), .RDATA(rdata), .PIN_RESET(src[0]),
		.BROWNOUT_RESET(src[1]), .TEST_PORT_RESET(src[2]), .OSC_128K(osc),
		.RESTART(restart), .ALWAYS_ON_FUSE_N(fuse_n), .GLOBAL_IRQ_EN(gie),
		.VECTOR_ACK(ack), .IRQ_REQ(irq_req), .SYS_RESET(sys_reset)
	);

	// ------------------------------------------------------------
	// clock, oscillator and watch counters
	// ------------------------------------------------------------
	always #12.5 clock = ~clock;

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		osc_div <= osc_div + 1;
		if (osc_div % 2 == 1)
			osc <= ~osc;
		if (sys_reset === 1'b1)
			sys_count <= sys_count + 1;
		if (cycles == LIMIT_CYCLES)
		begin
			err_count++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic io, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		io_space <= io;
		wdata <= d;
		write <= 1'b1;
		@(posedge clock);
		write <= 1'b0;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] want);
		samples_checked++;
		if (got !== want)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic io, input logic [7:0] want);
		@(posedge clock);
		addr <= a;
		io_space <= io;
		read <= 1'b1;
		@(posedge clock);
		read <= 1'b0;
		#1 chk8(rdata, want);
	endtask

	// wait for a level on one output, bounded
	task automatic wait_out(input logic irq, input int max, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge clock);
			#1 cnt++;
		end
		while (((irq ? irq_req : sys_reset) !== 1'b1) && cnt < max);
	endtask

	task automatic cfg(input logic [7:0] v);
		wr(CTRL_DS_ADDR, 1'b0, 8'h18);
		wr(CTRL_DS_ADDR, 1'b0, v);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		rd_chk(CAUSE_DS_ADDR, 1'b0, 8'h01);
		rd_chk(CAUSE_IO_ADDR, 1'b1, 8'h01);
		rd_chk(CTRL_DS_ADDR, 1'b0, CTRL_RESET);
		rd_chk(16'h0055, 1'b0, 8'h00);
		exp = 8'h01;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clock);
			src <= 3'(1 << i);
			@(posedge clock);
			src <= 3'h0;
			exp = exp | src_bit[i];
			rd_chk(CAUSE_DS_ADDR, 1'b0, exp);
		end
		wr(CAUSE_DS_ADDR, 1'b0, 8'hFF);
		rd_chk(CAUSE_DS_ADDR, 1'b0, 8'h17);
		wr(CAUSE_IO_ADDR, 1'b1, 8'h00);
		rd_chk(CAUSE_DS_ADDR, 1'b0, 8'h00);
		wr(CTRL_DS_ADDR, 1'b0, 8'h08);
		wr(CTRL_DS_ADDR, 1'b1, 8'h40);
		rd_chk(CTRL_DS_ADDR, 1'b1, 8'h00);
		wr(CTRL_DS_ADDR, 1'b0, 8'h00);
		rd_chk(CTRL_DS_ADDR, 1'b0, 8'h08);
		wr(CTRL_DS_ADDR, 1'b0, 8'h18);
		repeat (6) @(posedge clock);
		wr(CTRL_DS_ADDR, 1'b0, 8'h00);
		rd_chk(CTRL_DS_ADDR, 1'b0, 8'h08);
		// timeout length for plain, long and reserved codes
		foreach (codes[k])
		begin
			exp = {2'b00, 1'(codes[k] >> 3), 2'b01, 3'(codes[k])};
			base_count = OSC_PER * (BASE << ((codes[k] > 9) ? 9 : codes[k]));
			cfg(exp);
			// read lands in the last cycle of the unlock window, so bit 4 still shows
			rd_chk(CTRL_DS_ADDR, 1'b0, exp | 8'h10);
			@(posedge clock);
			restart <= 1'b0;
			wait_out(1'b0, base_count + 20, n);
			chk_rng(n, base_count - 6, base_count + 8);
			@(posedge clock);
			restart <= 1'b1;
			#1 chk8({7'h00, sys_reset}, 8'h00);
			rd_chk(CAUSE_DS_ADDR, 1'b0, 8'h08);
			cfg(8'h00);
			rd_chk(CTRL_DS_ADDR, 1'b0, 8'h18);
			// stored reset enable is zero, yet the pending flag keeps reset mode
			@(posedge clock);
			restart <= 1'b0;
			wait_out(1'b0, 40, n);
			chk_rng(n, 1, 39);
			@(posedge clock);
			restart <= 1'b1;
			wr(CAUSE_DS_ADDR, 1'b0, 8'h00);
			rd_chk(CTRL_DS_ADDR, 1'b0, 8'h00);
		end
		// interrupt mode with and without global enable
		n = sys_count;
		wr(CTRL_DS_ADDR, 1'b0, 8'h40);
		@(posedge clock);
		restart <= 1'b0;
		repeat (40) @(posedge clock);
		restart <= 1'b1;
		#1 chk8({7'h00, irq_req}, 8'h00);
		rd_chk(CTRL_DS_ADDR, 1'b0, 8'hC0);
		@(posedge clock);
		gie <= 1'b1;
		@(posedge clock);
		#1 chk8({7'h00, irq_req}, 8'h01);
		wr(CTRL_DS_ADDR, 1'b0, 8'hC0);
		rd_chk(CTRL_DS_ADDR, 1'b0, 8'h40);
		chk_rng(sys_count, n, n);
		wr(CTRL_DS_ADDR, 1'b0, 8'h00);
		// combined mode: vector taken, then not taken
		for (int j = 0; j < 2; j++)
		begin
			wr(CTRL_DS_ADDR, 1'b0, 8'h48);
			@(posedge clock);
			restart <= 1'b0;
			wait_out(1'b1, 40, n);
			chk_rng(n, 1, 39);
			if (j == 0)
			begin
				@(posedge clock);
				ack <= 1'b1;
				restart <= 1'b1;
				@(posedge clock);
				ack <= 1'b0;
				rd_chk(CTRL_DS_ADDR, 1'b0, 8'h08);
				@(posedge clock);
				restart <= 1'b0;
			end
			wait_out(1'b0, 40, n);
			chk_rng(n, 1, 39);
			@(posedge clock);
			restart <= 1'b1;
			wr(CAUSE_DS_ADDR, 1'b0, 8'h00);
		end
		// fuse forces reset mode
		@(posedge clock);
		fuse_n <= 1'b0;
		wr(CTRL_DS_ADDR, 1'b0, 8'h40);
		rd_chk(CTRL_DS_ADDR, 1'b0, 8'h08);
		@(posedge clock);
		restart <= 1'b0;
		wait_out(1'b0, 40, n);
		chk_rng(n, 1, 39);
		@(posedge clock);
		restart <= 1'b1;
		fuse_n <= 1'b1;
		wr(CAUSE_DS_ADDR, 1'b0, 8'h00);
		// stopped mode does nothing
		n = sys_count;
		@(posedge clock);
		restart <= 1'b0;
		repeat (60) @(posedge clock);
		rd_chk(CTRL_DS_ADDR, 1'b0, 8'h00);
		chk_rng(sys_count, n, n);
		conclude();
	end
endmodule
